// file: hdl/hcip_device.sv
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
module hcip_device
  import hcip_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Host bus
  hcip_bus_if.dev          bus,
  // Coprocessor side
  input  wire logic        cop_irq_req,
  input  wire logic        irq_route_en,
  input  wire logic [IDX_W-1:0] cop_idx,
  input  wire logic        cop_we,
  input  wire logic [7:0]  cop_wdata,
  output logic      [7:0]  cop_rdata,
  output logic             cop_reset,
  output logic             user_cmd_valid,
  output logic      [7:0]  user_cmd
);
  logic [7:0] rd_array [DEPTH];
  logic [7:0] wr_array [DEPTH];
  logic [IDX_W-1:0] ptr_reg;
  logic             auto_reg;
  logic             latch_reg;
  logic [2:0] a1, a2, a3;
  logic [7:0] d1, d2, d3;
  logic [1:0] r1, r2, r3;
  logic [1:0] w1, w2, w3;
  logic rd_now, wr_now, rd_prev, wr_prev;
  logic rd_rise, wr_rise;
  logic [1:0] sel;

  // Three-stage sampling of asynchronous host pins
  always_ff @(posedge core_clk) begin
    a1 <= bus.addr;  a2 <= a1; a3 <= a2;
    d1 <= bus.wdata; d2 <= d1; d3 <= d2;
    r1 <= {1'b0, ~bus.rd_n}; r2 <= r1; r3 <= r2;
    w1 <= {1'b0, ~bus.wr_n}; w2 <= w1; w3 <= w2;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_now <= 1'b0;
      wr_now <= 1'b0;
    end else begin
      if (r2[0] == r3[0]) rd_now <= r3[0];
      if (w2[0] == w3[0]) wr_now <= w3[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_now;
      wr_prev <= wr_now;
    end
  end

  assign rd_rise = rd_now & ~rd_prev;
  assign wr_rise = wr_now & ~wr_prev;
  assign sel     = d3[CMD_SEL_HI:CMD_SEL_LO];

  // Pointer and auto-step; the clear command never touches them
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ptr_reg  <= '0;
      auto_reg <= CMD_RESET_VAL[CMD_AUTO_BIT];
    end else if (wr_rise && a3 == PORT_CMD && sel == CMD_SET_PTR) begin
      ptr_reg  <= d3[IDX_W-1:0];
      auto_reg <= d3[CMD_AUTO_BIT];
    end else if ((wr_rise || rd_rise) && a3 == PORT_DATA && auto_reg) begin
      if (ptr_reg == IDX_W'(DEPTH - 1))
        ptr_reg <= '0;
      else
        ptr_reg <= ptr_reg + 1'b1;
    end
  end

  // Shared pointer into both arrays
  always_ff @(posedge core_clk) begin
    if (wr_rise && a3 == PORT_DATA)
      wr_array[ptr_reg] <= d3;
    if (cop_we)
      rd_array[cop_idx] <= cop_wdata;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bus.rdata <= '0;
    end else if (rd_rise) begin
      if (a3 == PORT_DATA)
        bus.rdata <= rd_array[ptr_reg];
      else
        bus.rdata <= {7'h00, latch_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) cop_rdata <= '0;
    else cop_rdata <= wr_array[cop_idx];
  end

  // Request latch: a new request wins over a simultaneous clear
  always_ff @(posedge core_clk) begin
    if (!reset_n)
      latch_reg <= 1'b0;
    else if (cop_irq_req)
      latch_reg <= 1'b1;
    else if (wr_rise && a3 == PORT_CMD && sel == CMD_CLEAR_IRQ)
      latch_reg <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) bus.irq <= 1'b0;
    else bus.irq <= latch_reg & irq_route_en;
  end

  // Reset follows the filtered write strobe, so it lasts as long
  always_ff @(posedge core_clk) begin
    if (!reset_n) cop_reset <= 1'b0;
    else cop_reset <= wr_now && a3 == PORT_STATUS;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      user_cmd_valid <= 1'b0;
      user_cmd       <= '0;
    end else begin
      user_cmd_valid <= wr_rise && a3 == PORT_CMD &&
                        (sel == CMD_USER1 || sel == CMD_USER2);
      if (wr_rise && a3 == PORT_CMD)
        user_cmd <= d3;
    end
  end
endmodule

// file: hdl/hcip_pkg.sv
// How it works
// - Command code zero loads index pointer
// - Auto-step advances pointer per data access
// - Pointer loads from low index field
// - Host writes pointer command bit four zero
// - Code three clears status and request
// - Host writes clear command bits five-one zero
// - Clear command leaves pointer and transfers alone
// - Host handler issues clear before exiting
// - Clear touches only the request latch (status bit and host request) and user_cmd
// - Only status bit zero carries meaning
// - Coprocessor request sets status; reset clears it
// - Request reaches host only when routing enabled
// - Request latch holds until cleared
// - Any status-location write resets coprocessor
// - Coprocessor reset lasts as long as strobe
// - Reset: pointer at zero, auto-step on
// - Auto-step wraps after last location
// - One pointer; reads read-array, writes write-array
package hcip_pkg;
  localparam int          ADDR_W        = 3;
  localparam logic [2:0]  PORT_DATA     = 3'h0;
  localparam logic [2:0]  PORT_CMD      = 3'h1;
  localparam logic [2:0]  PORT_STATUS   = 3'h2;
  localparam int          CMD_SEL_HI    = 7;
  localparam int          CMD_SEL_LO    = 6;
  localparam int          CMD_AUTO_BIT  = 5;
  localparam int          IDX_W         = 5;
  localparam logic [1:0]  CMD_SET_PTR   = 2'h0;
  localparam logic [1:0]  CMD_USER1     = 2'h1;
  localparam logic [1:0]  CMD_USER2     = 2'h2;
  localparam logic [1:0]  CMD_CLEAR_IRQ = 2'h3;
  localparam logic [7:0]  CMD_RESET_VAL = 8'h20;
  localparam logic [7:0]  CLEAR_IRQ_VAL = 8'hC0;
  // Avalon slave registers of the host controller
  localparam logic [3:0]  AV_CTRL       = 4'h0;
  localparam logic [3:0]  AV_WDATA      = 4'h4;
  localparam logic [3:0]  AV_RDATA      = 4'h8;
  localparam logic [3:0]  AV_IRQ_STAT   = 4'hC;
  localparam logic [3:0]  AV_IRQ_MASK   = 4'h0;
  localparam int          AV_ADDR_W     = 4;
  localparam int          HOST_STROBE   = 4;
endpackage

// file: hdl/hcip_bus_if.sv
`timescale 1ns/1ps
interface hcip_bus_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rd_n;
  logic       wr_n;
  logic       irq;
  modport dev  (input addr, wdata, rd_n, wr_n, output rdata, irq);
  modport host (output addr, wdata, rd_n, wr_n, input rdata, irq);
endinterface

// file: hdl/hcip_host.sv
`timescale 1ns/1ps
module hcip_host
  import hcip_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Avalon-MM slave
  input  wire logic [AV_ADDR_W-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      irq,
  // Device bus
  hcip_bus_if.host                  bus
);
  typedef enum {S_IDLE, S_STROBE, S_DONE} hcip_state_t;
  hcip_state_t state_reg;
  logic [2:0]  cnt_reg;
  logic        is_rd_reg;
  logic        mask_reg;
  logic        stat_reg;
  logic [7:0]  rbyte_reg;
  logic        irq_s1, irq_s2, irq_s3, irq_now, irq_prev;
  logic [2:0]  dev_addr;

  // Control word: bits 2:0 device port, access through AV_WDATA/AV_RDATA
  logic [2:0]  port_reg;
  assign dev_addr  = port_reg;

  always_ff @(posedge core_clk) begin
    irq_s1 <= bus.irq; irq_s2 <= irq_s1; irq_s3 <= irq_s2;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_now  <= 1'b0;
      irq_prev <= 1'b0;
    end else begin
      if (irq_s2 == irq_s3) irq_now <= irq_s3;
      irq_prev <= irq_now;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg       <= S_IDLE;
      cnt_reg         <= '0;
      is_rd_reg       <= 1'b0;
      bus.addr        <= '0;
      bus.wdata       <= '0;
      bus.rd_n        <= 1'b1;
      bus.wr_n        <= 1'b1;
      rbyte_reg       <= '0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          avs_waitrequest <= 1'b1;
          if ((avs_read || avs_write) && avs_address == AV_WDATA) begin
            // are software's duty on the data written
            bus.addr  <= dev_addr;
            bus.wdata <= avs_writedata[7:0];
            is_rd_reg <= avs_read;
            bus.rd_n  <= ~avs_read;
            bus.wr_n  <= ~avs_write;
            // Spare cycle: device read data lands one edge late
            cnt_reg   <= 3'(HOST_STROBE + 1);
            state_reg <= S_STROBE;
          end else if (avs_read || avs_write) begin
            avs_readdata    <= avs_address == AV_IRQ_STAT ?
                               {30'h0, mask_reg, stat_reg} :
                               avs_address == AV_RDATA ?
                               {24'h0, rbyte_reg} : {29'h0, port_reg};
            avs_waitrequest <= 1'b0;
            state_reg       <= S_DONE;
          end
        end
        S_STROBE: begin
          // Strobe held long enough for device sampling and filter
          if (cnt_reg == 3'h0) begin
            if (is_rd_reg) rbyte_reg <= bus.rdata;
            bus.rd_n        <= 1'b1;
            bus.wr_n        <= 1'b1;
            avs_readdata    <= {24'h0, bus.rdata};
            avs_waitrequest <= 1'b0;
            state_reg       <= S_DONE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        S_DONE: begin
          avs_waitrequest <= 1'b1;
          state_reg       <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  wire ctrl_wr = avs_write && !avs_waitrequest && state_reg == S_DONE;

  always_ff @(posedge core_clk) begin
    if (!reset_n) port_reg <= '0;
    else if (ctrl_wr && avs_address == AV_CTRL)
      port_reg <= avs_writedata[2:0];
  end

  // Sticky event on request edge; set wins over write-one clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (irq_now && !irq_prev) stat_reg <= 1'b1;
      else if (ctrl_wr && avs_address == AV_IRQ_STAT && avs_writedata[0])
        stat_reg <= 1'b0;
      if (ctrl_wr && avs_address == AV_IRQ_STAT)
        mask_reg <= avs_writedata[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) irq <= 1'b0;
    else irq <= stat_reg & mask_reg;
  end
endmodule

// file: verification/hcip_asserts.sv
`timescale 1ns/1ps
module hcip_asserts
  import hcip_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Device bus
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       irq,
  // Coprocessor side
  input wire logic       cop_irq_req,
  input wire logic       irq_route_en,
  input wire logic       cop_reset
);
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Age of the last clear command, so a hold check skips its latency
  logic [7:0] clr_age;
  always_ff @(posedge core_clk) begin
    if (!reset_n || (!wr_n && addr == PORT_CMD && wdata[7:6] == 2'b11))
      clr_age <= 8'h00;
    else if (clr_age != 8'hFF)
      clr_age <= clr_age + 8'h01;
  end
  a_strobes_apart: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  a_strobe_steady: assert property (!wr_n && $past(!wr_n) |->
    $stable(addr) && $stable(wdata))
    else $error("write qualifiers moved during strobe");
  a_strobe_long: assert property ($fell(wr_n) |-> (!wr_n)[*4])
    else $error("write strobe too short");
  a_no_route: assert property ((!irq_route_en)[*2] |=> !irq)
    else $error("host request without routing");
  a_irq_rise: assert property ((cop_irq_req && irq_route_en)
    ##1 irq_route_en[*4] |-> irq)
    else $error("host request not raised");
  a_irq_hold: assert property (irq && irq_route_en &&
    clr_age > 8'd8 |=> irq)
    else $error("host request dropped without clear");
  a_irq_clear: assert property ($rose(wr_n) && $past(addr) == PORT_CMD
    && $past(wdata[7:6]) == 2'b11 |-> ##[0:4] !irq)
    else $error("clear command left request high");
  a_stat_bits: assert property ($rose(rd_n) && $past(addr) != PORT_DATA
    |-> ##[0:2] rdata[7:1] == 7'h00)
    else $error("status upper bits not zero");
  a_reset_follow: assert property ((!wr_n && addr == PORT_STATUS)[*3]
    |-> ##[0:3] cop_reset)
    else $error("status write gave no coprocessor reset");
  a_reset_ends: assert property (wr_n[*6] |-> !cop_reset)
    else $error("coprocessor reset outlived strobe");
endmodule

// file: verification/host_command_and_irq_port_tb_top.sv
`timescale 1ns/1ps
module host_command_and_irq_port_tb_top
  import hcip_pkg::*;
;
  logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
  logic        cop_irq_req, irq_route_en, cop_we, cop_reset, ucv;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [4:0]  cop_idx;
  logic [7:0]  cop_wdata, cop_rdata, user_cmd, last_cmd;
  int          n_fail, n_tests, cyc, n_user, n_rst, n_str;
  hcip_bus_if  bus ();
  hcip_host hcip_host_i (.core_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .bus(bus));
  hcip_device #(.DEPTH(32)) hcip_device_i (.core_clk, .reset_n, .bus(bus),
    .cop_irq_req, .irq_route_en, .cop_idx, .cop_we, .cop_wdata, .cop_rdata,
    .cop_reset, .user_cmd_valid(ucv), .user_cmd);
  hcip_asserts hcip_asserts_i (.core_clk, .reset_n, .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .irq(bus.irq), .cop_irq_req, .irq_route_en, .cop_reset);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      final_report;
    end
    if (ucv === 1'b1) begin
      n_user <= n_user + 1;
      last_cmd <= user_cmd;
    end
    if (cop_reset === 1'b1) n_rst <= n_rst + 1;
    if (bus.wr_n === 1'b0 && bus.addr === PORT_STATUS) n_str <= n_str + 1;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low; the timeout ends hangs
  task automatic av(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic dev(logic wr, logic [2:0] p, logic [7:0] d);
    av(1'b1, AV_CTRL, {29'h0, p});
    av(wr, AV_WDATA, {24'h0, d});
    if (!wr) av(1'b0, AV_RDATA, 32'h0);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic pulse;
    @(posedge core_clk);
    cop_irq_req <= 1'b1;
    @(posedge core_clk);
    cop_irq_req <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic t_ptr;
    dev(0, PORT_DATA, 0);
    chk("first read", q[7:0], 8'hA0);
    dev(0, PORT_DATA, 0);
    chk("stepped read", q[7:0], 8'hA1);
    dev(1, PORT_CMD, 8'h2F);
    for (int i = 15; i < 31; i++) begin
      dev(0, PORT_DATA, 0);
      chk("sweep read", q[7:0], 8'hA0 + 8'(i));
    end
    dev(0, PORT_DATA, 0);
    chk("last entry", q[7:0], 8'hBF);
    dev(0, PORT_DATA, 0);
    chk("wrapped read", q[7:0], 8'hA0);
    dev(1, PORT_CMD, 8'h05);
    dev(1, PORT_DATA, 8'h11);
    dev(1, PORT_DATA, 8'h5A);
    dev(0, PORT_DATA, 0);
    chk("held read", q[7:0], 8'hA5);
    cop_idx <= 5'd5;
    repeat (3) @(posedge core_clk);
    chk("write array", cop_rdata, 8'h5A);
    $display("pointer test done");
  endtask
  task automatic t_irq;
    dev(1, PORT_CMD, 8'h2A);
    pulse;
    chk("unrouted", bus.irq, 1'b0);
    dev(0, PORT_STATUS, 0);
    chk("status set", q[0], 1'b1);
    dev(0, PORT_CMD, 0);
    chk("status at cmd", q[0], 1'b1);
    irq_route_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("routed", bus.irq, 1'b1);
    chk("masked", irq, 1'b0);
    av(1, AV_IRQ_STAT, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("unmasked", irq, 1'b1);
    dev(0, PORT_DATA, 0);
    dev(1, PORT_CMD, CLEAR_IRQ_VAL);
    chk("cleared", bus.irq, 1'b0);
    dev(0, PORT_DATA, 0);
    chk("ptr kept", q[7:0], 8'hAB);
    dev(0, PORT_STATUS, 0);
    chk("status clear", q[0], 1'b0);
    av(1, AV_IRQ_STAT, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("w1c", irq, 1'b0);
    pulse;
    repeat (2) @(posedge core_clk);
    chk("raised again", irq, 1'b1);
    av(1, AV_IRQ_STAT, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("mask off", irq, 1'b0);
    dev(1, PORT_CMD, CLEAR_IRQ_VAL);
    av(1, AV_IRQ_STAT, 32'h1);
    $display("interrupt test done");
  endtask
  task automatic t_rst;
    int r0 = n_rst;
    int s0 = n_str;
    dev(1, PORT_STATUS, 8'h5A);
    repeat (2) @(posedge core_clk);
    chk("reset seen", n_rst > r0, 1'b1);
    chk("reset length", n_rst - r0, n_str - s0);
    av(0, 4'h2, 0);
    chk("unmapped", q[2:0], PORT_STATUS);
    $display("coprocessor reset test done");
  endtask
  task automatic t_user;
    int u0 = n_user;
    dev(1, PORT_CMD, 8'h25);
    dev(1, PORT_CMD, 8'h45);
    chk("code one", last_cmd, 8'h45);
    dev(1, PORT_CMD, 8'h8A);
    chk("code two", last_cmd, 8'h8A);
    chk("user count", n_user - u0, 2);
    dev(0, PORT_DATA, 0);
    chk("ptr after user", q[7:0], 8'hA5);
    $display("user command test done");
  endtask
  initial begin
    {reset_n, avs_read, avs_write, cop_irq_req, irq_route_en, cop_we} = 0;
    {avs_address, avs_writedata, cop_idx, cop_wdata, last_cmd, q} = 0;
    {n_fail, n_tests, cyc, n_user, n_rst, n_str} = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk);
      cop_we <= 1'b1;
      cop_idx <= i[4:0];
      cop_wdata <= 8'hA0 ^ i[7:0];
    end
    @(posedge core_clk);
    cop_we <= 1'b0;
    t_ptr;
    t_irq;
    t_rst;
    t_user;
    final_report;
  end
endmodule
